// File: common/msr_pkg.sv
package msr_pkg;

	// ------------------------------------------------------------
	// Register offsets (relative to the relocatable register base)
	// ------------------------------------------------------------
	localparam logic [10:0] OFS_TEST_ZERO = 11'h014;
	localparam logic [10:0] OFS_TEST_ONE  = 11'h017;
	localparam logic [10:0] OFS_SIZE_A    = 11'h01c;
	localparam logic [10:0] OFS_SIZE_B    = 11'h01d;
	localparam logic [10:0] OFS_MISC_CTL  = 11'h013;
	localparam logic [10:0] OFS_RAM_POS   = 11'h010;
	localparam logic [10:0] OFS_REG_POS   = 11'h011;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SZA_REG_BIT  = 7;
	localparam int SZA_EEP_LO   = 4;
	localparam int SZA_RAM_LO   = 0;
	localparam int SZB_NVM_LO   = 6;
	localparam int SZB_PAG_LO   = 0;
	localparam int MISC_UHO_BIT = 1;
	localparam int RPOS_HAL_BIT = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RAM_POS_RESET  = 8'h09;
	localparam logic [7:0] REG_POS_RESET  = 8'h00;
	localparam logic [7:0] MISC_RESET     = 8'h0d;
	localparam logic [7:0] TEST_READ_VAL  = 8'h00;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        regspace_size_switch;
		logic [1:0]  eeprom_size_switch;
		logic [2:0]  ram_size_switch;
		logic [1:0]  nvm_size_switch;
		logic [1:0]  paging_split_switch;
	} msr_straps_t;

	typedef struct packed {
		logic [10:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} msr_req_t;

	typedef struct packed {
		logic [15:0] base;
		logic [15:0] span;
	} msr_window_t;

endpackage : msr_pkg

// File: hw/msr_ram_window.sv
// ------------------------------------------------------------
// RAM placement from size code, position and high-align bit
// ------------------------------------------------------------
module msr_ram_window (
	// Configuration
	input  wire logic [2:0]          ram_code,
	input  wire logic [7:0]          ram_pos,
	// Result
	output msr_pkg::msr_window_t     win
);
	logic [15:0] mask;
	logic [15:0] region;
	logic [15:0] alloc;
	logic [15:0] rbase;

	// Region mask and sizes per code
	always_comb begin
		case (ram_code)
			3'h0: mask = 16'hf800;
			3'h1: mask = 16'hf000;
			3'h2,
			3'h3: mask = 16'he000;
			default: mask = 16'hc000;
		endcase
		region = ~mask + 16'h0001;
		alloc  = {2'h0, ram_code, 11'h000} + 16'h0800;
		rbase  = {ram_pos[7:3], 11'h000} & mask;
		// High-align pushes a short RAM up against the region top
		if (ram_pos[msr_pkg::RPOS_HAL_BIT])
			win.base = rbase + (region - alloc);
		else
			win.base = rbase;
		win.span = alloc;
	end

endmodule : msr_ram_window

// File: hw/msr_size_regs.sv
module msr_size_regs (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	// Integration straps
	input  msr_pkg::msr_straps_t      straps,
	// Register port
	input  wire logic [15:0]          bus_addr,
	input  wire logic [7:0]           bus_wdata,
	input  wire logic                 bus_wr,
	input  wire logic                 bus_rd,
	output logic      [7:0]           bus_rdata,
	// Memory map probe
	input  wire logic [15:0]          probe_addr,
	output logic                      nvm_direct_ok,
	output logic      [15:0]          ram_base,
	output logic      [15:0]          ram_span
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0]  rdata_r, rdata_nxt;
	logic [7:0]  misc_r, misc_nxt;
	logic [7:0]  ram_pos_r, ram_pos_nxt;
	logic [7:0]  reg_pos_r, reg_pos_nxt;
	logic        ok_r, ok_nxt;
	logic [15:0] rbase_r, rbase_nxt;
	logic [15:0] rspan_r, rspan_nxt;
	logic [10:0] ofs;
	logic        hit;
	msr_pkg::msr_window_t win;
	logic [7:0]  size_a, size_b;

	// Window into the relocatable register block
	function automatic logic in_block(input logic [15:0] a,
		input logic [7:0] pos);
		in_block = (a[15:11] == {1'b0, pos[6:3]});
	endfunction : in_block

	assign hit = in_block(bus_addr, reg_pos_r);
	assign ofs = bus_addr[10:0];

	// Size words built straight from straps
	always_comb begin
		size_a = 8'h00;
		size_a[msr_pkg::SZA_REG_BIT] =
			straps.regspace_size_switch;
		size_a[msr_pkg::SZA_EEP_LO +: 2] =
			straps.eeprom_size_switch;
		size_a[msr_pkg::SZA_RAM_LO +: 3] =
			straps.ram_size_switch;
		size_b = 8'h00;
		size_b[msr_pkg::SZB_NVM_LO +: 2] =
			straps.nvm_size_switch;
		size_b[msr_pkg::SZB_PAG_LO +: 2] =
			straps.paging_split_switch;
	end

	msr_ram_window u_win (
		.ram_code (straps.ram_size_switch),
		.ram_pos  (ram_pos_r),
		.win      (win)
	);

	// Next values for read data, controls and map outputs
	always_comb begin
		rdata_nxt   = 8'h00;
		misc_nxt    = misc_r;
		ram_pos_nxt = ram_pos_r;
		reg_pos_nxt = reg_pos_r;
		if (bus_rd && hit) begin
			case (ofs)
				msr_pkg::OFS_TEST_ZERO,
				msr_pkg::OFS_TEST_ONE: rdata_nxt =
					msr_pkg::TEST_READ_VAL;
				msr_pkg::OFS_SIZE_A: rdata_nxt = size_a;
				msr_pkg::OFS_SIZE_B: rdata_nxt = size_b;
				msr_pkg::OFS_MISC_CTL: rdata_nxt = misc_r;
				msr_pkg::OFS_RAM_POS: rdata_nxt = ram_pos_r;
				msr_pkg::OFS_REG_POS: rdata_nxt = reg_pos_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
		// Writes to test and size locations fall through
		if (bus_wr && hit) begin
			case (ofs)
				msr_pkg::OFS_MISC_CTL: misc_nxt =
					{6'h00, bus_wdata[1:0]};
				msr_pkg::OFS_RAM_POS: ram_pos_nxt =
					{bus_wdata[7:3], 2'h0, bus_wdata[0]};
				msr_pkg::OFS_REG_POS: reg_pos_nxt =
					{1'b0, bus_wdata[6:3], 3'h0};
				default: ;
			endcase
		end
		// Lower half direct access blocked by upper-half bit
		ok_nxt = misc_r[0] &&
			!(misc_r[msr_pkg::MISC_UHO_BIT] && !probe_addr[15]);
		rbase_nxt = win.base;
		rspan_nxt = win.span;
	end

	// Register stage
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_r   <= 8'h00;
			misc_r    <= msr_pkg::MISC_RESET;
			ram_pos_r <= msr_pkg::RAM_POS_RESET;
			reg_pos_r <= msr_pkg::REG_POS_RESET;
			ok_r      <= 1'b0;
			rbase_r   <= 16'h0000;
			rspan_r   <= 16'h0000;
		end else begin
			rdata_r   <= rdata_nxt;
			misc_r    <= misc_nxt;
			ram_pos_r <= ram_pos_nxt;
			reg_pos_r <= reg_pos_nxt;
			ok_r      <= ok_nxt;
			rbase_r   <= rbase_nxt;
			rspan_r   <= rspan_nxt;
		end
	end

	assign bus_rdata     = rdata_r;
	assign nvm_direct_ok = ok_r;
	assign ram_base      = rbase_r;
	assign ram_span      = rspan_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_test_write_ignored;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_wr && hit && (ofs == msr_pkg::OFS_TEST_ZERO ||
			ofs == msr_pkg::OFS_TEST_ONE)) |=>
			(misc_r == $past(misc_r) && ram_pos_r == $past(ram_pos_r));
	endproperty
	a_test_write_ignored: assert property (p_test_write_ignored)
		else $error("test location write changed state");

	property p_size_a_read;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && ofs == msr_pkg::OFS_SIZE_A) |=>
			bus_rdata == {$past(straps.regspace_size_switch), 1'b0,
			$past(straps.eeprom_size_switch), 1'b0,
			$past(straps.ram_size_switch)};
	endproperty
	a_size_a_read: assert property (p_size_a_read)
		else $error("size A read mismatch");

	property p_size_b_read;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && ofs == msr_pkg::OFS_SIZE_B) |=>
			bus_rdata == {$past(straps.nvm_size_switch), 4'h0,
			$past(straps.paging_split_switch)};
	endproperty
	a_size_b_read: assert property (p_size_b_read)
		else $error("size B read mismatch");

	property p_miss_reads_zero;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && !hit) |=> bus_rdata == 8'h00;
	endproperty
	a_miss_reads_zero: assert property (p_miss_reads_zero)
		else $error("read outside register block returned data");

	property p_ram_pos_reset;
		@(posedge clk_sys)
		!reset_n |=> ram_pos_r == 8'h09;
	endproperty
	a_ram_pos_reset: assert property (p_ram_pos_reset)
		else $error("RAM position reset value wrong");

	property p_lower_blocked;
		@(posedge clk_sys) disable iff (!reset_n)
		(misc_r[1] && !probe_addr[15]) |=> !nvm_direct_ok;
	endproperty
	a_lower_blocked: assert property (p_lower_blocked)
		else $error("lower half flash reachable with upper-half bit");

	property p_upper_ok;
		@(posedge clk_sys) disable iff (!reset_n)
		(misc_r[0] && probe_addr[15]) |=> nvm_direct_ok;
	endproperty
	a_upper_ok: assert property (p_upper_ok)
		else $error("upper half flash blocked");

	property p_span;
		@(posedge clk_sys) disable iff (!reset_n)
		reset_n |=> ram_span ==
			({2'h0, $past(straps.ram_size_switch), 11'h000} + 16'h0800);
	endproperty
	a_span: assert property (p_span)
		else $error("RAM span does not follow code");

	property p_full_region_base;
		@(posedge clk_sys) disable iff (!reset_n)
		(straps.ram_size_switch == 3'h7) |=>
			ram_base[13:0] == 14'h0000;
	endproperty
	a_full_region_base: assert property (p_full_region_base)
		else $error("full RAM base not region aligned");

	property p_eep_field;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && ofs == msr_pkg::OFS_SIZE_A) |=>
			bus_rdata[5:4] == $past(straps.eeprom_size_switch)
			&& bus_rdata[7] == $past(straps.regspace_size_switch);
	endproperty
	a_eep_field: assert property (p_eep_field)
		else $error("EEPROM or register size field wrong");

	property p_ram_field;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && ofs == msr_pkg::OFS_SIZE_A) |=>
			bus_rdata[2:0] == $past(straps.ram_size_switch);
	endproperty
	a_ram_field: assert property (p_ram_field)
		else $error("RAM size field wrong");

	property p_nvm_field;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && ofs == msr_pkg::OFS_SIZE_B) |=>
			bus_rdata[7:6] == $past(straps.nvm_size_switch);
	endproperty
	a_nvm_field: assert property (p_nvm_field)
		else $error("flash size field wrong");

	property p_pag_field;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && ofs == msr_pkg::OFS_SIZE_B) |=>
			bus_rdata[1:0] == $past(straps.paging_split_switch);
	endproperty
	a_pag_field: assert property (p_pag_field)
		else $error("paging split field wrong");

	property p_size_b_zero;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && ofs == msr_pkg::OFS_SIZE_B) |=>
			bus_rdata[5:2] == 4'h0;
	endproperty
	a_size_b_zero: assert property (p_size_b_zero)
		else $error("size B middle bits not zero");

	property p_test_read;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_rd && hit && (ofs == msr_pkg::OFS_TEST_ZERO ||
			ofs == msr_pkg::OFS_TEST_ONE)) |=>
			bus_rdata == msr_pkg::TEST_READ_VAL;
	endproperty
	a_test_read: assert property (p_test_read)
		else $error("test location read value wrong");

	property p_size_write_ignored;
		@(posedge clk_sys) disable iff (!reset_n)
		(bus_wr && hit && (ofs == msr_pkg::OFS_SIZE_A ||
			ofs == msr_pkg::OFS_SIZE_B)) |=>
			($stable(misc_r) && $stable(ram_pos_r) && $stable(reg_pos_r));
	endproperty
	a_size_write_ignored: assert property (p_size_write_ignored)
		else $error("size location write changed state");

	property p_rdata_idle;
		@(posedge clk_sys) disable iff (!reset_n)
		!bus_rd |=> bus_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data held past its cycle");

	property p_hal_top;
		@(posedge clk_sys) disable iff (!reset_n)
		(reset_n && straps.ram_size_switch == 3'h2 &&
			ram_pos_r[msr_pkg::RPOS_HAL_BIT]) |=>
			ram_base[12:0] == 13'h0800;
	endproperty
	a_hal_top: assert property (p_hal_top)
		else $error("high-aligned 6K RAM not at region top");

	property p_hal_bottom;
		@(posedge clk_sys) disable iff (!reset_n)
		(reset_n && straps.ram_size_switch == 3'h2 &&
			!ram_pos_r[msr_pkg::RPOS_HAL_BIT]) |=>
			ram_base[12:0] == 13'h0000;
	endproperty
	a_hal_bottom: assert property (p_hal_bottom)
		else $error("low-aligned 6K RAM not at region bottom");

	property p_reset_base_top;
		@(posedge clk_sys) disable iff (!reset_n)
		(reset_n && ram_pos_r == msr_pkg::RAM_POS_RESET &&
			straps.ram_size_switch[2]) |=>
			(ram_base + ram_span) == 16'h4000;
	endproperty
	a_reset_base_top: assert property (p_reset_base_top)
		else $error("reset RAM does not end at region top");

	property p_nvm_off;
		@(posedge clk_sys) disable iff (!reset_n)
		(reset_n && !misc_r[0]) |=> !nvm_direct_ok;
	endproperty
	a_nvm_off: assert property (p_nvm_off)
		else $error("flash reachable while disabled");

endmodule : msr_size_regs

// File: tb/msr_size_regs_bench.sv
module msr_size_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                 clk_sys   = 1'b0;
	logic                 reset_n   = 1'b0;
	msr_pkg::msr_straps_t straps    = '0;
	logic [15:0]          bus_addr  = 16'h0000;
	logic [7:0]           bus_wdata = 8'h00;
	logic                 bus_wr    = 1'b0;
	logic                 bus_rd    = 1'b0;
	logic [7:0]           bus_rdata;
	logic [15:0]          probe_addr = 16'h0000;
	logic                 nvm_direct_ok;
	logic [15:0]          ram_base;
	logic [15:0]          ram_span;
	int                   failures  = 0;
	int                   n_tests   = 0;

	// Expected RAM base after reset, one entry per RAM size code
	localparam logic [15:0] RAM_BASE [8] = '{16'h0800, 16'h0000,
		16'h0800, 16'h0000, 16'h1800, 16'h1000, 16'h0800, 16'h0000};

	// Clock at 100 ns period
	always #50 clk_sys = ~clk_sys;

	// ------------------------------------------------------------
	// Device under test
	// ------------------------------------------------------------
	msr_size_regs uut (
		.clk_sys(clk_sys), .reset_n(reset_n), .straps(straps),
		.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_rdata(bus_rdata), .probe_addr(probe_addr),
		.nvm_direct_ok(nvm_direct_ok), .ram_base(ram_base),
		.ram_span(ram_span)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge clk_sys);
		bus_wr    <= 1'b0;
	endtask : bus_write

	// Read data stand only in the cycle after the strobe
	task automatic rdchk(input string nm, input logic [15:0] a,
		input logic [7:0] exp);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge clk_sys);
		bus_rd   <= 1'b0;
		#1;
		chk(nm, {8'h00, bus_rdata}, {8'h00, exp});
	endtask : rdchk

	task automatic probe(input logic [15:0] a, input logic exp);
		@(posedge clk_sys);
		probe_addr <= a;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("nvm_direct_ok", {15'h0, nvm_direct_ok}, {15'h0, exp});
	endtask : probe

	task automatic base_chk(input logic [15:0] exp);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("ram_base", ram_base, exp);
	endtask : base_chk

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	// Main sequence
	initial begin
		logic [2:0] c;
		logic [7:0] ea;
		logic [7:0] eb;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		// Every strap code, fields and reset RAM placement
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			ea = {c[0], 1'b0, c[1:0], 1'b0, c};
			eb = {c[1:0], 4'h0, ~c[1:0]};
			@(posedge clk_sys);
			straps <= msr_pkg::msr_straps_t'(
				{c[0], c[1:0], c, c[1:0], ~c[1:0]});
			rdchk("size_a", 16'h001c, ea);
			rdchk("size_b", 16'h001d, eb);
			chk("ram_base", ram_base, RAM_BASE[c]);
			chk("ram_span", ram_span, ({13'h0, c} + 16'h1) << 11);
		end
		$display("test size fields done");
		// Writes to read-only places leave them unchanged
		bus_write(16'h0014, 8'hff);
		rdchk("test_zero", 16'h0014, 8'h00);
		bus_write(16'h0017, 8'hff);
		rdchk("test_one", 16'h0017, 8'h00);
		bus_write(16'h001c, 8'h48);
		rdchk("size_a", 16'h001c, 8'hb7);
		bus_write(16'h001d, 8'h3f);
		rdchk("size_b", 16'h001d, 8'hc0);
		$display("test write ignore done");
		// Relocated register base
		bus_write(16'h0011, 8'h08);
		rdchk("size_a_moved", 16'h081c, 8'hb7);
		rdchk("size_a_old", 16'h001c, 8'h00);
		bus_write(16'h0811, 8'h00);
		rdchk("size_b_back", 16'h001d, 8'hc0);
		$display("test relocation done");
		// Flash direct access gating
		rdchk("misc_reset", 16'h0013, msr_pkg::MISC_RESET);
		probe(16'h4000, 1'b1);
		bus_write(16'h0013, 8'h03);
		probe(16'h4000, 1'b0);
		probe(16'hc000, 1'b1);
		bus_write(16'h0013, 8'h02);
		probe(16'hc000, 1'b0);
		$display("test upper half done");
		// Alignment of 6K RAM inside its 8K region
		@(posedge clk_sys);
		straps <= msr_pkg::msr_straps_t'(10'h020);
		base_chk(16'h0800);
		bus_write(16'h0010, 8'h08);
		base_chk(16'h0000);
		bus_write(16'h0010, 8'h29);
		base_chk(16'h2800);
		rdchk("ram_pos", 16'h0010, 8'h29);
		$display("test ram align done");
		tally_and_finish();
	end

	// Watchdog against a hung run
	initial begin
		#1000000;
		failures++;
		tally_and_finish();
	end

endmodule : msr_size_regs_bench
